/* File: ttw_defs.svh */
// constants for the two/three-wire terminal start control
`ifndef TTW_DEFS_SVH
`define TTW_DEFS_SVH

// terminal function codes
`define TTW_FN_PRESET_FREQ 8'h07
`define TTW_FN_TWO_FWD 8'h30
`define TTW_FN_THREE_START 8'h31
`define TTW_FN_TWO_REV 8'h32
`define TTW_FN_THREE_DIR 8'h33
`define TTW_FN_PULSE_TRAIN 8'h34

// start source value for the terminal block
`define TTW_SRC_TERMINAL 4'h2

// two-wire trigger modes
`define TTW_MODE_EDGE 2'h0
`define TTW_MODE_LEVEL 2'h1
`define TTW_MODE_FAST 2'h2
`define TTW_MODE_MOMENTARY 2'h3

// timing: clock rate, contact debounce time and fast start limit
`define TTW_CLK_MHZ 40
`define TTW_DEBOUNCE_US 1000
`define TTW_DEBOUNCE_CYC (`TTW_DEBOUNCE_US * `TTW_CLK_MHZ)
`define TTW_FAST_START_MS 10
`define TTW_FAST_START_CYC (`TTW_FAST_START_MS * 1000 * `TTW_CLK_MHZ)

`endif

/* File: ttw_pkg.sv */
// types for the two/three-wire terminal start control
`default_nettype none
package ttw_pkg;
    typedef enum logic [1:0] {
        TTW_IDLE = 2'b01,
        TTW_RUN = 2'b10
    } ttw_state_e;
endpackage
`default_nettype wire

/* File: ttw_debounce.sv */
// contact debouncer: an input must hold a new level for a full window
`timescale 1ns/1ps
`default_nettype none
module ttw_debounce #(
    parameter int N = 3,
    parameter int CYCLES = 40000
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [N-1:0] raw,
    output logic [N-1:0] clean
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_bit
            logic [CW-1:0] cnt_r;
            logic differ;
            assign differ = raw[i] != clean[i];
            // restart the window on any bounce back to the old level
            always_ff @(posedge mclk) begin
                if (!nrst) begin
                    cnt_r <= '0;
                    clean[i] <= 1'b0;
                end else if (!differ) begin
                    cnt_r <= '0;
                end else if (cnt_r == LAST) begin
                    cnt_r <= '0;
                    clean[i] <= raw[i];
                end else begin
                    cnt_r <= cnt_r + 1'b1;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* File: ttw_cfg_decode.sv */
// decodes terminal function settings into enables and illegal pairings
`timescale 1ns/1ps
`default_nettype none
`include "ttw_defs.svh"
module ttw_cfg_decode (
    input wire logic [7:0] terminal_two_function,
    input wire logic [7:0] terminal_three_function,
    input wire logic [7:0] terminal_five_function,
    input wire logic [7:0] terminal_seven_function,
    input wire logic [3:0] active_source,
    input wire logic variant_large,
    output logic tb_src,
    output logic two_fwd_en,
    output logic two_rev_en,
    output logic three_start_en,
    output logic three_dir_en,
    output logic pair_refused,
    output logic pulse05_en,
    output logic pulse07_en,
    output logic pulse_misplaced
);
    function automatic logic fn_is(input logic [7:0] fn, input logic [7:0] code);
        fn_is = fn == code;
    endfunction

    logic three_blocked;

    // small variant loses the 3-wire pair when terminal 03 is a preset
    assign three_blocked = !variant_large && fn_is(terminal_three_function, `TTW_FN_PRESET_FREQ);
    assign tb_src = active_source == `TTW_SRC_TERMINAL;
    assign two_fwd_en = fn_is(terminal_two_function, `TTW_FN_TWO_FWD);
    assign three_start_en = fn_is(terminal_two_function, `TTW_FN_THREE_START) && !three_blocked;
    assign two_rev_en = fn_is(terminal_three_function, `TTW_FN_TWO_REV);
    assign three_dir_en = fn_is(terminal_three_function, `TTW_FN_THREE_DIR) && !three_blocked;
    // mixed 2-wire and 3-wire pairs never start
    assign pair_refused = (fn_is(terminal_two_function, `TTW_FN_THREE_START) && two_rev_en)
                       || (two_fwd_en && fn_is(terminal_three_function, `TTW_FN_THREE_DIR));
    // pulse train only on terminal 05 (small) or 07 (large)
    assign pulse05_en = !variant_large && fn_is(terminal_five_function, `TTW_FN_PULSE_TRAIN);
    assign pulse07_en = variant_large && fn_is(terminal_seven_function, `TTW_FN_PULSE_TRAIN);
    assign pulse_misplaced = fn_is(terminal_two_function, `TTW_FN_PULSE_TRAIN)
                          || fn_is(terminal_three_function, `TTW_FN_PULSE_TRAIN)
                          || (variant_large && fn_is(terminal_five_function, `TTW_FN_PULSE_TRAIN))
                          || (!variant_large && fn_is(terminal_seven_function, `TTW_FN_PULSE_TRAIN));
endmodule
`default_nettype wire

/* File: ttw_start_control.sv */
// start/stop control from terminals 01, 02 and 03 in 2-wire or 3-wire use
// How it works
// - Terminal 02 means 2-wire forward (48) or 3-wire start (49), only with the terminal block (2) as start source.
// - Terminal 03 means 2-wire reverse (50) or 3-wire direction (51), the latter picking the running direction.
// - Code 52 routes a pulse-train speed input, allowed only on terminal 05 (small) or 07 (large variant).
// - A 3-wire start with 2-wire reverse, or 2-wire forward with 3-wire direction, refuses to start.
// - The trigger mode acts only on terminals 02/03 in 2-wire use with the terminal block as source.
// - Mode 0 is the reset default edge start; in mode 1 a stop coasts and a held run restarts once stop clears.
// - In level mode a held run resumes without a toggle and stop acts only while the stop input is open.
// - In mode 2 the outputs stay ready to run, a start is answered within 10 ms and a stop coasts.
// - In mode 3 a momentary pulse on terminal 02 or 03 starts the drive without being held.
// - In mode 3 a stop on terminal 01 follows the configured stop behaviour, not a forced coast.
// - On the small variant, terminal 03 set to preset frequency (7) disables both 3-wire functions.
`timescale 1ns/1ps
`default_nettype none
`include "ttw_defs.svh"
module ttw_start_control #(
    parameter int DEBOUNCE_CYCLES = `TTW_DEBOUNCE_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic stop_closed,
    input wire logic term02_in,
    input wire logic term03_in,
    input wire logic term05_in,
    input wire logic term07_in,
    input wire logic [7:0] terminal_two_function,
    input wire logic [7:0] terminal_three_function,
    input wire logic [7:0] terminal_five_function,
    input wire logic [7:0] terminal_seven_function,
    input wire logic [1:0] two_wire_trigger_mode,
    input wire logic [2:0] stop_behaviour_select,
    input wire logic [3:0] start_source_first,
    input wire logic [3:0] start_source_second,
    input wire logic [3:0] start_source_third,
    input wire logic [1:0] source_select,
    input wire logic variant_large,
    output logic run_cmd,
    output logic reverse_cmd,
    output logic coast_stop,
    output logic ramp_stop,
    output logic [2:0] stop_mode_out,
    output logic ready_to_run,
    output logic start_refused,
    output logic pulse_train_sel,
    output logic pulse_train_out,
    output logic config_error
);
    ttw_pkg::ttw_state_e state_r, state_nxt;
    logic [2:0] db;
    logic stop_db, t02_db, t03_db, t02_q, t03_q;
    logic [3:0] active_source;
    logic tb_src, two_fwd_en, two_rev_en, three_start_en, three_dir_en;
    logic pair_refused, pulse05_en, pulse07_en, pulse_misplaced;
    logic run_r, reverse_r, coast_r, ramp_r, ready_r, refused_r, psel_r, pout_r, cerr_r;
    logic [2:0] smode_r;

    // the three start terminals share one debouncer bank
    ttw_debounce #(
        .N(3),
        .CYCLES(DEBOUNCE_CYCLES)
    ) u_deb (
        .mclk(mclk),
        .nrst(nrst),
        .raw({stop_closed, term03_in, term02_in}),
        .clean(db)
    );
    assign t02_db = db[0];
    assign t03_db = db[1];
    assign stop_db = db[2];

    // pick which of the three start source settings is in force
    assign active_source = (source_select == 2'h1) ? start_source_second :
                           (source_select == 2'h2) ? start_source_third : start_source_first;

    ttw_cfg_decode u_cfg (
        .terminal_two_function(terminal_two_function),
        .terminal_three_function(terminal_three_function),
        .terminal_five_function(terminal_five_function),
        .terminal_seven_function(terminal_seven_function),
        .active_source(active_source),
        .variant_large(variant_large),
        .tb_src(tb_src),
        .two_fwd_en(two_fwd_en),
        .two_rev_en(two_rev_en),
        .three_start_en(three_start_en),
        .three_dir_en(three_dir_en),
        .pair_refused(pair_refused),
        .pulse05_en(pulse05_en),
        .pulse07_en(pulse07_en),
        .pulse_misplaced(pulse_misplaced)
    );

    // edges only ever see debounced levels, so bounce cannot double-start
    logic fwd_rise, rev_rise, stop_open;
    assign fwd_rise = t02_db && !t02_q;
    assign rev_rise = t03_db && !t03_q;
    assign stop_open = !stop_db;

    // operating mode decode; trigger mode is ignored outside 2-wire terminal use
    logic two_wire, three_wire, m_level, m_fast, m_mom;
    assign two_wire = tb_src && (two_fwd_en || two_rev_en) && !three_start_en;
    assign three_wire = tb_src && three_start_en;
    assign m_level = two_wire && two_wire_trigger_mode == `TTW_MODE_LEVEL;
    assign m_fast = two_wire && two_wire_trigger_mode == `TTW_MODE_FAST;
    assign m_mom = two_wire && two_wire_trigger_mode == `TTW_MODE_MOMENTARY;

    // run requests from each 2-wire terminal
    logic fwd_held, rev_held, fwd_go, rev_go, start_ev, hold_ok, go, stop_now, coast_kind;
    assign fwd_held = two_fwd_en && t02_db;
    assign rev_held = two_rev_en && t03_db;
    assign fwd_go = two_fwd_en && (m_level ? t02_db : fwd_rise);
    assign rev_go = two_rev_en && (m_level ? t03_db : rev_rise);
    assign start_ev = three_wire ? fwd_rise : (two_wire && (fwd_go || rev_go));

    // 2-wire edge, level and fast modes run only while the chosen run input is held
    assign hold_ok = three_wire || m_mom || (reverse_r ? rev_held : fwd_held);
    assign go = start_ev && !stop_open && !pair_refused;
    assign stop_now = stop_open || pair_refused || !(two_wire || three_wire) || !hold_ok;
    // level and fast modes coast; others use the configured stop behaviour
    assign coast_kind = m_level || m_fast;

    // run state: idle until a start event, running until a stop condition
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ttw_pkg::TTW_IDLE: begin
                if (go) begin
                    state_nxt = ttw_pkg::TTW_RUN;
                end
            end
            ttw_pkg::TTW_RUN: begin
                if (stop_now) begin
                    state_nxt = ttw_pkg::TTW_IDLE;
                end
            end
            default: state_nxt = ttw_pkg::TTW_IDLE;
        endcase
    end

    // direction at start: 3-wire follows terminal 03, 2-wire picks the requesting input (held in level mode), forward if both
    logic dir_nxt;
    assign dir_nxt = three_wire ? (three_dir_en && t03_db) : (!fwd_go && rev_go);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_r <= ttw_pkg::TTW_IDLE;
            t02_q <= 1'b0;
            t03_q <= 1'b0;
        end else begin
            state_r <= state_nxt;
            t02_q <= t02_db;
            t03_q <= t03_db;
        end
    end

    // command outputs; 3-wire direction tracks terminal 03 while running
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            run_r <= 1'b0;
            reverse_r <= 1'b0;
        end else begin
            run_r <= state_nxt == ttw_pkg::TTW_RUN;
            if (state_r == ttw_pkg::TTW_IDLE && go) begin
                reverse_r <= dir_nxt;
            end else if (state_r == ttw_pkg::TTW_RUN && three_wire) begin
                reverse_r <= three_dir_en && t03_db;
            end
        end
    end

    // stop kind: coast in level and fast modes, configured behaviour otherwise
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            coast_r <= 1'b0;
            ramp_r <= 1'b0;
            smode_r <= 3'h0;
        end else if (state_r == ttw_pkg::TTW_RUN && stop_now) begin
            coast_r <= coast_kind;
            ramp_r <= !coast_kind;
            smode_r <= stop_behaviour_select;
        end else if (state_nxt == ttw_pkg::TTW_RUN) begin
            coast_r <= 1'b0;
            ramp_r <= 1'b0;
        end
    end

    // status and pulse-train routing; pulse input is not debounced to keep its rate
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ready_r <= 1'b0;
            refused_r <= 1'b0;
            psel_r <= 1'b0;
            pout_r <= 1'b0;
            cerr_r <= 1'b0;
        end else begin
            ready_r <= m_fast;
            refused_r <= tb_src && pair_refused;
            psel_r <= pulse05_en || pulse07_en;
            pout_r <= (pulse05_en && term05_in) || (pulse07_en && term07_in);
            cerr_r <= pulse_misplaced || pair_refused;
        end
    end

    assign run_cmd = run_r;
    assign reverse_cmd = reverse_r;
    assign coast_stop = coast_r;
    assign ramp_stop = ramp_r;
    assign stop_mode_out = smode_r;
    assign ready_to_run = ready_r;
    assign start_refused = refused_r;
    assign pulse_train_sel = psel_r;
    assign pulse_train_out = pout_r;
    assign config_error = cerr_r;

    // fast-mode response counter for the start latency check
    logic [24:0] fast_wait_r;
    always_ff @(posedge mclk) begin
        if (!nrst || !m_fast || run_r || !(fwd_held || rev_held) || stop_open) begin
            fast_wait_r <= '0;
        end else if (fast_wait_r != 25'h1FFFFFF) begin
            fast_wait_r <= fast_wait_r + 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    refused_no_run_a: assert property (pair_refused |=> !run_r && !$rose(run_r))
        else $error("started with an illegal terminal pairing");
    source_gate_a: assert property (!tb_src |=> ##1 !run_r)
        else $error("running without the terminal block as start source");
    level_coast_a: assert property (run_r && m_level && stop_open && $stable(two_wire_trigger_mode)
        |=> coast_r && !run_r)
        else $error("level mode stop did not coast");
    level_resume_a: assert property (!run_r && m_level && !stop_open && fwd_held && !pair_refused
        && $stable(two_wire_trigger_mode) |=> run_r)
        else $error("held run did not resume in level mode");
    fast_latency_a: assert property (fast_wait_r < 25'(`TTW_FAST_START_CYC))
        else $error("fast start not answered in time");
    fast_ready_a: assert property (m_fast |=> ready_to_run)
        else $error("ready output missing in fast mode");
    mom_latch_a: assert property (run_r && m_mom && !stop_open && !pair_refused
        && $stable(m_mom) ##1 !t02_db && !t03_db |-> run_r)
        else $error("momentary start dropped when pulse ended");
    mom_stop_a: assert property (run_r && m_mom && stop_open
        |=> ramp_stop && !coast_stop && stop_mode_out == $past(stop_behaviour_select))
        else $error("momentary stop did not use configured behaviour");
    small_block_a: assert property (!variant_large && terminal_three_function == `TTW_FN_PRESET_FREQ
        |-> !three_start_en && !three_dir_en)
        else $error("3-wire functions not disabled by preset on terminal 03");
    pulse_place_a: assert property (pulse_train_sel |-> $past(pulse05_en || pulse07_en))
        else $error("pulse train routed from a disallowed terminal");
    one_start_a: assert property ($rose(run_r) && !m_level |=> !$rose(run_r) [*4])
        else $error("single closure produced a second start");

    three_wire_c: cover property (three_wire && $rose(run_r));
    level_restart_c: cover property (m_level && $fell(run_r) ##[1:200] $rose(run_r));
    mom_run_c: cover property (m_mom && $rose(run_r) ##[1:50] !t02_db && run_r);
    refuse_c: cover property (start_refused && fwd_rise);
endmodule
`default_nettype wire

/* File: ttw_contacts.sv */
// behavioural model of the stop, run forward and run reverse contacts on terminals 01 to 03
`timescale 1ns/1ps
`default_nettype none
module ttw_contacts (
    input wire logic mclk,
    input wire logic want_stop_closed,
    input wire logic [1:0] want_run,
    input wire logic bounce,
    output logic stop_closed,
    output logic term02_in,
    output logic term03_in
);
    logic [2:0] cur;
    logic [2:0] prev;
    logic [2:0] old;
    int n_b;

    // contacts are dry and always at a solid level, so there is nothing floating to model
    initial begin
        prev = 3'h4;
        old = 3'h4;
        n_b = 0;
        {stop_closed, term02_in, term03_in} = 3'h4;
    end

    // a commanded bounce chatters for three cycles, shorter than any sane filter window;
    // these contacts are the only command source, nothing from a network competes
    always @(posedge mclk) begin
        cur = {want_stop_closed, want_run[0], want_run[1]};
        if (cur !== prev) begin
            old = prev;
            prev = cur;
            n_b = bounce ? 3 : 0;
        end
        {stop_closed, term02_in, term03_in} <= #2 (n_b % 2 == 1) ? old : cur;
        if (n_b > 0)
            n_b = n_b - 1;
    end
endmodule
`default_nettype wire

/* File: two_three_wire_start_control_tb.sv */
// self-checking bench for the two/three-wire terminal start control
`timescale 1ns/1ps
`default_nettype none
`include "ttw_defs.svh"
module two_three_wire_start_control_tb;
    localparam int D = 4;
    localparam logic [7:0] FWD = `TTW_FN_TWO_FWD;
    localparam logic [7:0] REV = `TTW_FN_TWO_REV;
    localparam logic [7:0] T3S = `TTW_FN_THREE_START;
    localparam logic [7:0] T3D = `TTW_FN_THREE_DIR;
    logic mclk, nrst, want_stop, bounce, term05_in, term07_in, variant_large;
    logic stop_closed, term02_in, term03_in, run_q;
    logic [1:0] wrun, mode, source_select;
    logic [7:0] fn2, fn3, fn5, fn7;
    logic [2:0] stop_sel, stop_mode_out;
    logic [3:0] src1, src2, src3;
    logic run_cmd, reverse_cmd, coast_stop, ramp_stop, ready_to_run, start_refused;
    logic pulse_train_sel, pulse_train_out, config_error;
    int n_mismatch = 0;
    int check_count = 0;
    int n_rise = 0;
    int base;

    ttw_contacts contacts (.mclk(mclk), .want_stop_closed(want_stop), .want_run(wrun), .bounce(bounce),
        .stop_closed(stop_closed), .term02_in(term02_in), .term03_in(term03_in));

    ttw_start_control #(.DEBOUNCE_CYCLES(D)) DUT (.mclk(mclk), .nrst(nrst), .stop_closed(stop_closed),
        .term02_in(term02_in), .term03_in(term03_in), .term05_in(term05_in), .term07_in(term07_in),
        .terminal_two_function(fn2), .terminal_three_function(fn3), .terminal_five_function(fn5),
        .terminal_seven_function(fn7), .two_wire_trigger_mode(mode), .stop_behaviour_select(stop_sel),
        .start_source_first(src1), .start_source_second(src2), .start_source_third(src3),
        .source_select(source_select), .variant_large(variant_large), .run_cmd(run_cmd),
        .reverse_cmd(reverse_cmd), .coast_stop(coast_stop), .ramp_stop(ramp_stop),
        .stop_mode_out(stop_mode_out), .ready_to_run(ready_to_run), .start_refused(start_refused),
        .pulse_train_sel(pulse_train_sel), .pulse_train_out(pulse_train_out), .config_error(config_error));

    // 25 ns clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // counts starts so that a chattering closure can be seen to give only one
    always @(posedge mclk) begin
        run_q <= run_cmd;
        if (run_cmd === 1'b1 && run_q === 1'b0)
            n_rise <= n_rise + 1;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
        end
    endtask

    // inputs always move 2 ns after the rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    // bounded wait: contact, filter window and state register all add delay
    task automatic wait_run(input logic v, input string msg);
        int i;
        i = 0;
        while (run_cmd !== v && i < 2 * D + 6) begin
            cyc(1);
            i++;
        end
        chk(8'(run_cmd), 8'(v), msg);
    endtask

    // open the stop before touching the settings so nothing changes under a running drive
    task automatic setup(input logic [7:0] f2, input logic [7:0] f3, input logic [1:0] m);
        wrun = 2'h0;
        want_stop = 1'b0;
        cyc(D + 4);
        fn2 = f2;
        fn3 = f3;
        mode = m;
        want_stop = 1'b1;
        cyc(D + 4);
    endtask

    task automatic tap(input int k);
        wrun[k] = 1'b1;
        cyc(D + 2);
        wrun[k] = 1'b0;
    endtask

    initial begin
        #(25 * 6000);
        n_mismatch++;
        finish_test();
    end

    initial begin
        {nrst, want_stop, bounce, term05_in, term07_in, variant_large} = 6'h10;
        {fn2, fn3, fn5, fn7} = {FWD, REV, 16'h0000};
        {mode, source_select, wrun, stop_sel} = 9'h005;
        {src1, src2, src3} = 12'h200;
        repeat (3) @(posedge mclk);
        #2;
        nrst = 1'b1;
        cyc(1);
        chk(8'(run_cmd), 8'h00, "reset run");
        // edge start forward, release stops, then a chattering closure
        setup(FWD, REV, `TTW_MODE_EDGE);
        chk(8'(start_refused), 8'h00, "pair ok");
        chk(8'(ready_to_run), 8'h00, "ready edge");
        wrun = 2'h1;
        wait_run(1'b1, "edge start");
        chk(8'(reverse_cmd), 8'h00, "fwd dir");
        wrun = 2'h0;
        wait_run(1'b0, "edge release");
        base = n_rise;
        bounce = 1'b1;
        wrun = 2'h1;
        wait_run(1'b1, "bounce start");
        cyc(D + 4);
        chk(8'(n_rise - base), 8'h01, "one start");
        bounce = 1'b0;
        want_stop = 1'b0;
        wait_run(1'b0, "edge stop");
        chk({ramp_stop, coast_stop, 3'h0, stop_mode_out}, 8'h85, "edge stop kind");
        want_stop = 1'b1;
        cyc(D + 6);
        chk(8'(run_cmd), 8'h00, "edge no restart");
        setup(FWD, REV, `TTW_MODE_EDGE);
        wrun = 2'h2;
        wait_run(1'b1, "rev start");
        chk(8'(reverse_cmd), 8'h01, "rev dir");
        $display("test edge done");
        // level sense: coast on stop, held run resumes untoggled
        setup(FWD, REV, `TTW_MODE_LEVEL);
        wrun = 2'h1;
        wait_run(1'b1, "level start");
        want_stop = 1'b0;
        wait_run(1'b0, "level stop");
        chk(8'(coast_stop), 8'h01, "level coast");
        want_stop = 1'b1;
        wait_run(1'b1, "level resume");
        $display("test level done");
        // fast edge: ready flag, prompt start, coast stop
        setup(FWD, REV, `TTW_MODE_FAST);
        chk(8'(ready_to_run), 8'h01, "ready fast");
        wrun = 2'h1;
        wait_run(1'b1, "fast start");
        want_stop = 1'b0;
        wait_run(1'b0, "fast stop");
        chk(8'(coast_stop), 8'h01, "fast coast");
        $display("test fast done");
        // momentary on each run input; stop follows the stop behaviour select
        stop_sel = 3'h2;
        for (int k = 0; k < 2; k++) begin
            setup(FWD, REV, `TTW_MODE_MOMENTARY);
            tap(k);
            wait_run(1'b1, "mom start");
            cyc(D + 4);
            chk({6'h00, run_cmd, reverse_cmd}, 8'(2 + k), "mom latched");
            want_stop = 1'b0;
            wait_run(1'b0, "mom stop");
            chk({ramp_stop, coast_stop, 3'h0, stop_mode_out}, 8'h82, "mom stop kind");
        end
        $display("test momentary done");
        // three-wire: trigger mode has no say, 03 steers live
        setup(T3S, T3D, `TTW_MODE_LEVEL);
        tap(0);
        wait_run(1'b1, "3w start");
        chk(8'(reverse_cmd), 8'h00, "3w fwd");
        wrun = 2'h2;
        cyc(D + 4);
        chk({6'h00, run_cmd, reverse_cmd}, 8'h03, "3w rev");
        want_stop = 1'b0;
        wait_run(1'b0, "3w stop");
        chk(8'(ramp_stop), 8'h01, "3w ramp");
        $display("test three wire done");
        // mixed pairings refuse, preset frequency on small variant blocks 3-wire
        for (int k = 0; k < 3; k++) begin
            setup(k == 1 ? FWD : T3S, k == 0 ? REV : (k == 1 ? T3D : `TTW_FN_PRESET_FREQ), `TTW_MODE_EDGE);
            chk({start_refused, config_error}, k < 2 ? 8'h03 : 8'h00, "refusal flags");
            wrun = 2'h1;
            cyc(2 * D + 6);
            chk(8'(run_cmd), 8'h00, "refused start");
        end
        $display("test refusal done");
        // start source must be the terminal block, found through the source select
        src1 = 4'h1;
        setup(FWD, REV, `TTW_MODE_EDGE);
        wrun = 2'h1;
        cyc(2 * D + 6);
        chk(8'(run_cmd), 8'h00, "src off");
        wrun = 2'h0;
        src2 = `TTW_SRC_TERMINAL;
        source_select = 2'h1;
        cyc(D + 4);
        wrun = 2'h1;
        wait_run(1'b1, "src second");
        $display("test source done");
        // pulse train only on 05 for small and 07 for large
        fn5 = `TTW_FN_PULSE_TRAIN;
        cyc(2);
        chk(8'(pulse_train_sel), 8'h01, "pulse 05");
        term05_in = 1'b1;
        cyc(1);
        chk(8'(pulse_train_out), 8'h01, "pulse 05 pin");
        variant_large = 1'b1;
        cyc(2);
        chk({pulse_train_sel, config_error}, 8'h01, "pulse 05 large");
        {fn5, fn7} = {8'h00, `TTW_FN_PULSE_TRAIN};
        term07_in = 1'b0;
        cyc(2);
        term07_in = 1'b1;
        chk({pulse_train_sel, pulse_train_out, config_error}, 8'h04, "pulse 07");
        cyc(1);
        chk(8'(pulse_train_out), 8'h01, "pulse 07 pin");
        $display("test pulse done");
        finish_test();
    end
endmodule
`default_nettype wire
